// ### verilog/pab_consts.svh
// Overview of operation
// [RULE1] Most pins reset with every setting zero
// [RULE2] Software input: output off, input on
// [RULE3] Software output: output on, input off
// [RULE4] Analog role: output, pulls, input off
// [RULE5] Port B pin 1 resets as debug clock
// [RULE6] Port B pin 2 resets as debug data
// [RULE7] Receive input: first select, input on
// [RULE8] Transmit output: first select, output on
// [RULE9] Serial clock: first select, direction by enable
// [RULE10] Interrupt inputs: output off, input on
// [RULE11] During reset boot pin is pulled-up input
// [RULE12] Boot pin high at release: flash boot
// [RULE13] Boot pin low at release: boot program
// [RULE14] Software enables one function select per pin
// [RULE15] Open drain releases pin while driving one
// [RULE16] Unimplemented setting bits read zero, ignore writes
// [RULE17] Selected peripheral replaces data on the pin
`ifndef PAB_CONSTS_SVH
`define PAB_CONSTS_SVH

`define PAB_ADDR_W        8
`define PAB_PORT_A        2'h0
`define PAB_PORT_B        2'h1
`define PAB_OFF_DATA      6'h00
`define PAB_OFF_OE        6'h04
`define PAB_OFF_FS1       6'h08
`define PAB_OFF_FS2       6'h0c
`define PAB_OFF_OD        6'h28
`define PAB_OFF_PU        6'h2c
`define PAB_OFF_PD        6'h30
`define PAB_OFF_IE        6'h38

`define PAB_RESP_OKAY     2'h0
`define PAB_RESP_SLVERR   2'h2

`define PAB_A_FS1_MASK    8'h00
`define PAB_A_FS2_MASK    8'h00
`define PAB_B_FS1_MASK    8'h0e
`define PAB_B_FS2_MASK    8'h06

`define PAB_ZERO8         8'h00
`define PAB_B_RST_OE      8'h04
`define PAB_B_RST_FS2     8'h06
`define PAB_B_RST_PU      8'h04
`define PAB_B_RST_PD      8'h02
`define PAB_B_RST_IE      8'h06
`define PAB_B_HOLD_PU     8'h05
`define PAB_B_HOLD_IE     8'h07

`define PAB_BIT_PORT_SEL  6
`define PAB_BIT_UNMAPPED  7
`define PAB_BIT_BOOT      0
`define PAB_BIT_RXD       1
`define PAB_BIT_TXD       2
`define PAB_BIT_SCLK      3
`define PAB_BIT_INT_LO    5

`endif

// ### verilog/pab_pkg.sv
`default_nettype none
package pab_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
		logic [7:0] fs1;
		logic [7:0] fs2;
		logic [7:0] od;
		logic [7:0] pu;
		logic [7:0] pd;
		logic [7:0] ie;
	} pab_pincfg_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
		logic [7:0] pd;
		logic [7:0] ie;
	} pab_pad_t;

	typedef enum logic [3:0] {
		REG_DATA, REG_OE, REG_FS1, REG_FS2, REG_OD, REG_PU, REG_PD, REG_IE, REG_NONE
	} pab_reg_t;
endpackage
`default_nettype wire

// ### verilog/pab_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
`include "pab_consts.svh"
module pab_pin_cell #(
	parameter logic [7:0] HOLD_PU = `PAB_ZERO8,
	parameter logic [7:0] HOLD_IE = `PAB_ZERO8
) (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// Settings and peripheral sources
	input  wire pab_pkg::pab_pincfg_t cfg,
	input  wire logic [7:0]           alt1_out,
	input  wire logic [7:0]           alt2_out,
	// Pins
	input  wire logic [7:0]           pin_in,
	output var  pab_pkg::pab_pad_t    pad,
	output logic [7:0]                pin_q
);
	import pab_pkg::*;

	wire [7:0] port_mode = ~(cfg.fs1 | cfg.fs2);
	wire [7:0] out_val   = (cfg.fs1 & alt1_out) | (cfg.fs2 & ~cfg.fs1 & alt2_out)
		| (port_mode & cfg.data);  // [RULE17]
	// Pseudo open drain: buffer off for a one, pull-up or outside lifts the line
	wire [7:0] oe_eff    = cfg.oe & ~(cfg.od & out_val);  // [RULE15]

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// Pads have output off in reset, pull-up only where HOLD_PU is set, input only where HOLD_IE is set; boot pin held as pulled-up input
			pad.out <= `PAB_ZERO8;
			pad.oe  <= `PAB_ZERO8;  // [RULE11]
			pad.pu  <= HOLD_PU;  // [RULE11]
			pad.pd  <= `PAB_ZERO8;
			pad.ie  <= HOLD_IE;
			pin_q   <= `PAB_ZERO8;
		end
		else
		begin
			pad.out <= out_val;
			pad.oe  <= oe_eff;
			pad.pu  <= cfg.pu;
			pad.pd  <= cfg.pd;
			pad.ie  <= cfg.ie;
			pin_q   <= pin_in & cfg.ie;
		end
	end
endmodule // pab_pin_cell
`default_nettype wire

// ### verilog/pab_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pab_consts.svh"
module pab_top (
	// Clock and reset
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	// AXI4-Lite write address
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [`PAB_ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	// AXI4-Lite write response
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [`PAB_ADDR_W-1:0]    s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	// AXI4-Lite read data
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// Port A pins
	input  wire logic [7:0]                porta_pin_in,
	output var  pab_pkg::pab_pad_t         porta_pad,
	// Port B pins
	input  wire logic [7:0]                portb_pin_in,
	output var  pab_pkg::pab_pad_t         portb_pad,
	// Serial channel
	input  wire logic                      serial_channel_transmit,
	input  wire logic                      serial_channel_clock_out,
	output logic                           serial_channel_receive,
	output logic                           serial_channel_clock_in,
	// Serial-wire debug
	input  wire logic                      debug_data_out,
	output logic                           debug_clock,
	output logic                           debug_data_in,
	// External interrupt inputs
	output logic [2:0]                     external_interrupt,
	// Boot selection
	output logic                           boot_flash,
	output logic                           boot_valid
);
	import pab_pkg::*;

	pab_pincfg_t cfg_q [2];
	pab_pincfg_t cfg_d [2];
	logic [7:0]  pin_q [2];
	logic [`PAB_ADDR_W-1:0] awaddr_q;
	logic [7:0]  wbyte_q;
	logic        wen_q;
	logic        boot_armed_q;

	// Address decoding shared by both channels
	function automatic pab_reg_t decode_reg(input logic [`PAB_ADDR_W-1:0] addr);
		logic [5:0] off;
		off = addr[5:0];
		if (addr[`PAB_BIT_UNMAPPED] || addr[1:0] != 2'h0)
			decode_reg = REG_NONE;
		else if (off == `PAB_OFF_DATA)
			decode_reg = REG_DATA;
		else if (off == `PAB_OFF_OE)
			decode_reg = REG_OE;
		else if (off == `PAB_OFF_FS1 && addr[`PAB_BIT_PORT_SEL])
			decode_reg = REG_FS1;
		else if (off == `PAB_OFF_FS2 && addr[`PAB_BIT_PORT_SEL])
			decode_reg = REG_FS2;
		else if (off == `PAB_OFF_OD)
			decode_reg = REG_OD;
		else if (off == `PAB_OFF_PU)
			decode_reg = REG_PU;
		else if (off == `PAB_OFF_PD)
			decode_reg = REG_PD;
		else if (off == `PAB_OFF_IE)
			decode_reg = REG_IE;
		else
			decode_reg = REG_NONE;
	endfunction

	// Apply one byte write; select bits without a function stay zero
	function automatic pab_pincfg_t write_cfg(input pab_pincfg_t cur, input pab_reg_t r,
		input logic [7:0] v, input logic [7:0] m1, input logic [7:0] m2);
		pab_pincfg_t n;
		n = cur;
		case (r)
			REG_DATA: n.data = v;
			REG_OE:   n.oe   = v;
			REG_FS1:  n.fs1  = v & m1;  // [RULE16]
			REG_FS2:  n.fs2  = v & m2;  // [RULE16]
			REG_OD:   n.od   = v;
			REG_PU:   n.pu   = v;
			REG_PD:   n.pd   = v;
			REG_IE:   n.ie   = v;
			default:  n      = cur;
		endcase
		write_cfg = n;
	endfunction

	// Data reads show the pin where input is enabled, the latch elsewhere
	function automatic logic [7:0] read_cfg(input pab_pincfg_t c, input pab_reg_t r,
		input logic [7:0] pins);
		case (r)
			REG_DATA: read_cfg = (c.ie & pins) | (~c.ie & c.data);
			REG_OE:   read_cfg = c.oe;
			REG_FS1:  read_cfg = c.fs1;
			REG_FS2:  read_cfg = c.fs2;
			REG_OD:   read_cfg = c.od;
			REG_PU:   read_cfg = c.pu;
			REG_PD:   read_cfg = c.pd;
			REG_IE:   read_cfg = c.ie;
			default:  read_cfg = `PAB_ZERO8;
		endcase
	endfunction

	// Write path: address and data may arrive in either order
	wire       aw_take  = s_axi_awvalid & s_axi_awready;
	wire       w_take   = s_axi_wvalid & s_axi_wready;
	wire       wr_fire  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire [1:0] wr_port  = {1'b0, awaddr_q[`PAB_BIT_PORT_SEL]};
	pab_reg_t  wr_reg;
	assign wr_reg = decode_reg(awaddr_q);
	wire       wr_hit   = (wr_reg != REG_NONE);
	wire       wr_do    = wr_fire & wr_hit & wen_q;
	wire       b_done   = s_axi_bvalid & s_axi_bready;

	// Read path: answered on the same edge that takes the address
	wire       ar_take  = s_axi_arvalid & s_axi_arready;
	pab_reg_t  rd_reg;
	assign rd_reg = decode_reg(s_axi_araddr);
	wire       rd_b     = s_axi_araddr[`PAB_BIT_PORT_SEL];
	wire [7:0] rd_byte  = rd_b ? read_cfg(cfg_q[1], rd_reg, pin_q[1])
		: read_cfg(cfg_q[0], rd_reg, pin_q[0]);
	wire       r_done   = s_axi_rvalid & s_axi_rready;

	assign cfg_d[0] = (wr_do && wr_port == `PAB_PORT_A)
		? write_cfg(cfg_q[0], wr_reg, wbyte_q, `PAB_A_FS1_MASK, `PAB_A_FS2_MASK) : cfg_q[0];
	assign cfg_d[1] = (wr_do && wr_port == `PAB_PORT_B)
		? write_cfg(cfg_q[1], wr_reg, wbyte_q, `PAB_B_FS1_MASK, `PAB_B_FS2_MASK) : cfg_q[1];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PAB_RESP_OKAY;
			awaddr_q      <= '0;
			wbyte_q       <= `PAB_ZERO8;
			wen_q         <= 1'b0;
		end
		else
		begin
			if (aw_take)
			begin
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end
			if (w_take)
			begin
				s_axi_wready <= 1'b0;
				wbyte_q      <= s_axi_wdata[7:0];
				wen_q        <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `PAB_RESP_OKAY : `PAB_RESP_SLVERR;
			end
			if (b_done)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `PAB_RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};  // [RULE16]
			s_axi_rresp   <= (rd_reg == REG_NONE) ? `PAB_RESP_SLVERR : `PAB_RESP_OKAY;
		end
		else if (r_done)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Settings; port B debug pins come up in their debug role
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_q[0] <= '0;  // [RULE1]
			cfg_q[1] <= '{data: `PAB_ZERO8, oe: `PAB_B_RST_OE, fs1: `PAB_ZERO8,
				fs2: `PAB_B_RST_FS2, od: `PAB_ZERO8, pu: `PAB_B_RST_PU,
				pd: `PAB_B_RST_PD, ie: `PAB_B_RST_IE};  // [RULE1] [RULE5] [RULE6]
		end
		else
		begin
			cfg_q[0] <= cfg_d[0];
			cfg_q[1] <= cfg_d[1];
		end
	end

	// Port A carries no digital alternate; analog pins need all enables off
	pab_pin_cell #(
		.HOLD_PU (`PAB_ZERO8),
		.HOLD_IE (`PAB_ZERO8)
	) u_porta (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.cfg      (cfg_q[0]),
		.alt1_out (`PAB_ZERO8),
		.alt2_out (`PAB_ZERO8),
		.pin_in   (porta_pin_in),
		.pad      (porta_pad),
		.pin_q    (pin_q[0])
	);  // [RULE4]

	wire [7:0] b_alt1 = {4'h0, serial_channel_clock_out, serial_channel_transmit, 2'h0};  // [RULE8] [RULE9]
	wire [7:0] b_alt2 = {5'h00, debug_data_out, 2'h0};  // [RULE6]

	pab_pin_cell #(
		.HOLD_PU (`PAB_B_HOLD_PU),
		.HOLD_IE (`PAB_B_HOLD_IE)
	) u_portb (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.cfg      (cfg_q[1]),
		.alt1_out (b_alt1),
		.alt2_out (b_alt2),
		.pin_in   (portb_pin_in),
		.pad      (portb_pad),
		.pin_q    (pin_q[1])
	);  // [RULE11]

	// Serial and debug inputs only see a pin whose function is selected
	wire [7:0] b_sel1 = pin_q[1] & cfg_q[1].fs1;
	wire [7:0] b_sel2 = pin_q[1] & cfg_q[1].fs2;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_channel_receive  <= 1'b0;
			serial_channel_clock_in <= 1'b0;
			debug_clock             <= 1'b0;
			debug_data_in           <= 1'b0;
			external_interrupt      <= 3'h0;
		end
		else
		begin
			serial_channel_receive  <= b_sel1[`PAB_BIT_RXD];  // [RULE7]
			serial_channel_clock_in <= b_sel1[`PAB_BIT_SCLK] & ~cfg_q[1].oe[`PAB_BIT_SCLK];  // [RULE9]
			debug_clock             <= b_sel2[`PAB_BIT_RXD];  // [RULE5]
			debug_data_in           <= b_sel2[`PAB_BIT_TXD];  // [RULE6]
			// Pin input is already gated by its input enable
			external_interrupt      <= pin_q[1][`PAB_BIT_INT_LO +: 3];  // [RULE10] [RULE2]
		end
	end

	// Boot pin is sampled once, on the first edge after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			boot_armed_q <= 1'b1;
			boot_flash   <= 1'b0;
			boot_valid   <= 1'b0;
		end
		else if (boot_armed_q)
		begin
			boot_armed_q <= 1'b0;
			boot_flash   <= portb_pin_in[`PAB_BIT_BOOT];  // [RULE12] [RULE13]
			boot_valid   <= 1'b1;
		end
	end
endmodule // pab_top
`default_nettype wire

// ### bench/pab_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module pab_pins_model (
	// Clock
	input  wire logic              aclk,
	// Pads of the block
	input  wire pab_pkg::pab_pad_t pad_a,
	input  wire pab_pkg::pab_pad_t pad_b,
	// Outside drivers: enable and value
	input  wire logic [7:0]        drv_a,
	input  wire logic [7:0]        val_a,
	input  wire logic [7:0]        drv_b,
	input  wire logic [7:0]        val_b,
	// Pin levels
	output logic [7:0]             pin_a,
	output logic [7:0]             pin_b
);
	import pab_pkg::*;
	logic [7:0] fl_q = 8'h55;
	// A floating pin wanders so that no steady level can be relied on
	always @(posedge aclk)
		fl_q <= ~fl_q;
	function automatic logic [7:0] lvl(pab_pad_t p, logic [7:0] d, logic [7:0] v, logic [7:0] f);
		return (p.oe & p.out) | (~p.oe & ((d & v) | (~d & (p.pu | (~p.pd & f)))));
	endfunction
	assign pin_a = lvl(pad_a, drv_a, val_a, fl_q);
	assign pin_b = lvl(pad_b, drv_b, val_b, fl_q);
endmodule // pab_pins_model
`default_nettype wire

// ### bench/pab_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pab_properties (
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Bus
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic [31:0]       s_axi_rdata,
	// Pins and status
	input wire pab_pkg::pab_pad_t porta_pad,
	input wire pab_pkg::pab_pad_t portb_pad,
	input wire logic [7:0]        portb_pin_in,
	input wire logic [2:0]        external_interrupt,
	input wire logic              boot_flash,
	input wire logic              boot_valid
);
	import pab_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_release;
		!aresetn ##1 aresetn;
	endsequence
	sequence s_in_reset;
		!aresetn ##1 !aresetn;
	endsequence
	property p_boot_hold;
		disable iff (1'b0) s_in_reset |-> portb_pad.pu[0] && portb_pad.ie[0] && !portb_pad.oe[0];
	endproperty
	a_boot_hold: assert property (p_boot_hold)
		else $error("boot pin not a pulled-up input");
	property p_boot_mode;
		disable iff (1'b0) s_release |=> boot_valid && boot_flash == $past(portb_pin_in[0]);
	endproperty
	a_boot_mode: assert property (p_boot_mode)
		else $error("boot mode not taken from pin");
	property p_rst_pads;
		disable iff (1'b0) s_release |=> porta_pad == 40'h0 && portb_pad[31:0] == 32'h04040206;
	endproperty
	a_rst_pads: assert property (p_rst_pads)
		else $error("pad defaults wrong");
	property p_boot_keep;
		boot_valid |=> boot_valid && $stable(boot_flash);
	endproperty
	a_boot_keep: assert property (p_boot_keep)
		else $error("boot mode changed");
	property p_irq;
		($stable(portb_pad.ie[7:5]) && $stable(portb_pin_in[7:5]))[*3]
			|-> external_interrupt == (portb_pin_in[7:5] & portb_pad.ie[7:5]);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt input mismatch");
	property p_rdata_hi;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rdata_hi: assert property (p_rdata_hi)
		else $error("unused read bits set");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_answer: assert property (p_r_answer)
		else $error("read answer late");
	property p_b_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer)
		else $error("write answer late");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy)
		else $error("write taken while answering");
endmodule // pab_properties
bind pab_top pab_properties i_pab_properties (.*);
`default_nettype wire

// ### bench/pab_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pab_top_bench;
	import pab_pkg::*;
	localparam logic [7:0] OFF [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h28, 8'h2c, 8'h30, 8'h38};
	localparam logic [7:0] RB [8] = '{8'h00, 8'h04, 8'h00, 8'h06, 8'h00, 8'h04, 8'h02, 8'h06};
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic serial_channel_transmit = 1'b0, serial_channel_clock_out = 1'b0, debug_data_out = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [7:0] ea_d = 8'h00, ea_v = 8'h00, eb_d = 8'h00, eb_v = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic serial_channel_receive, serial_channel_clock_in, debug_clock, debug_data_in;
	logic boot_flash, boot_valid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [2:0] external_interrupt;
	logic [7:0] porta_pin_in, portb_pin_in;
	pab_pad_t porta_pad, portb_pad;
	int error_cnt = 0, checks_done = 0, cyc = 0;
	pab_top i_pab_top (.*);
	pab_pins_model i_pab_pins_model (.aclk(aclk), .pad_a(porta_pad), .pad_b(portb_pad),
		.drv_a(ea_d), .val_a(ea_v), .drv_b(eb_d), .val_b(eb_v),
		.pin_a(porta_pin_in), .pin_b(portb_pin_in));
	initial forever #50 aclk = ~aclk;
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// A hung handshake must still end in the verdict
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	task chk(input logic [39:0] g, input logic [39:0] e);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
	endtask
	task rst;
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask
	// Peripheral source to input output crosses pad, pin and output flops
	task st;
		repeat (4) @(posedge aclk);
	endtask
	initial
	begin
		rst();
		chk({boot_valid, boot_flash}, 2'h3);
		chk(porta_pad, 40'h0);
		chk(portb_pad[31:0], 32'h04040206);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 8; i++)
				rd((p ? 8'h40 : 8'h00) | OFF[i], p ? RB[i] : 8'h00,
					(p == 0 && i inside {2, 3}) ? 2'h2 : 2'h0);
		rd(8'h80, 8'h00, 2'h2);
		$display("test reset values done");
		eb_d <= 8'hff;
		eb_v <= 8'h02;
		debug_data_out <= 1'b1;
		st();
		chk({debug_clock, debug_data_in, portb_pad.out[2], portb_pad.oe[2]}, 4'hf);
		wr(8'h4c, 8'h00, 2'h0);
		wr(8'h48, 8'hff, 2'h0);
		rd(8'h48, 8'h0e, 2'h0);
		wr(8'h08, 8'h01, 2'h2);
		$display("test debug and select bits done");
		wr(8'h00, 8'ha5, 2'h0);
		wr(8'h04, 8'hff, 2'h0);
		st();
		chk({porta_pad.out, porta_pad.oe}, 16'ha5ff);
		wr(8'h28, 8'hff, 2'h0);
		st();
		chk(porta_pad.oe, 8'h5a);
		rd(8'h00, 8'ha5, 2'h0);
		wr(8'h04, 8'h00, 2'h0);
		wr(8'h38, 8'hff, 2'h0);
		ea_d <= 8'hff;
		ea_v <= 8'h3c;
		st();
		rd(8'h00, 8'h3c, 2'h0);
		wr(8'h38, 8'h00, 2'h0);
		st();
		chk(porta_pad[31:0], 32'h0);
		rd(8'h00, 8'ha5, 2'h0);
		$display("test port a roles done");
		wr(8'h4c, 8'h00, 2'h0);
		wr(8'h48, 8'h0e, 2'h0);
		wr(8'h44, 8'h0c, 2'h0);
		wr(8'h78, 8'h02, 2'h0);
		serial_channel_transmit <= 1'b1;
		serial_channel_clock_out <= 1'b1;
		st();
		chk({serial_channel_receive, portb_pad.out[3:2], portb_pad.oe[3:2]}, 5'h1f);
		eb_v[1] <= 1'b0;
		serial_channel_transmit <= 1'b0;
		st();
		chk({serial_channel_receive, portb_pad.out[2]}, 2'h0);
		wr(8'h44, 8'h04, 2'h0);
		wr(8'h78, 8'h0a, 2'h0);
		eb_v[3] <= 1'b1;
		st();
		chk(serial_channel_clock_in, 1'b1);
		eb_v[3] <= 1'b0;
		st();
		chk(serial_channel_clock_in, 1'b0);
		$display("test serial channel done");
		wr(8'h78, 8'he0, 2'h0);
		eb_v[7:5] <= 3'h5;
		st();
		chk(external_interrupt, 3'h5);
		wr(8'h78, 8'h00, 2'h0);
		st();
		chk(external_interrupt, 3'h0);
		$display("test interrupt inputs done");
		eb_v[0] <= 1'b0;
		rst();
		chk({boot_valid, boot_flash}, 2'h2);
		$display("test boot program done");
		finish_test();
	end
endmodule // pab_top_bench
`default_nettype wire
